// ---- rtl/keypad_service_test_params.svh ----
// Purpose: constants of the keypad service test sequencer
// Assumes: included by its bare name
// Notes: definitions only
`ifndef KEYPAD_SERVICE_TEST_PARAMS_SVH
`define KEYPAD_SERVICE_TEST_PARAMS_SVH
// --------
// port and switch addresses
// --------
`define FRONT_PANEL_PORT_A 16'h9808
`define FRONT_PANEL_PORT_B 16'h980A
`define VCO_PROGRAM_LOW 16'h9820
`define VCO_PROGRAM_HIGH 16'h9822
`define TUNING_FREQ_LOW 16'h9840
`define TUNING_FREQ_HIGH 16'h9842
`define BAND2_CONVERTER_PORT_A 16'h9880
`define BAND2_CONVERTER_PORT_B 16'h9882
`define GATE_GENERATOR_PORT_A 16'h9900
`define GATE_GENERATOR_PORT_B 16'h9902
`define BCD_REMOTE_PORT_A 16'h9A00
`define BCD_REMOTE_PORT_B 16'h9A02
`define DAC_BOARD_PORT_A 16'hA820
`define DAC_BOARD_PORT_B 16'hA822
`define COUNT_CHAIN_PORT_A 16'hAC00
`define COUNT_CHAIN_PORT_B 16'hAC02
`define BUS_ADDRESS_SWITCH 16'h9C04
`define RAM_LIMIT 16'h0800
`define NUM_PORTS 16
// port pairs, index of the a side divided by two
`define PAIR_VCO 3'h1
`define PAIR_TUNE 3'h2
`define PAIR_GATE 3'h4
`define PAIR_DAC 3'h6
// --------
// key coordinates, row then column
// --------
`define KEY_0 8'h12
`define KEY_1 8'h21
`define KEY_2 8'h22
`define KEY_3 8'h23
`define KEY_4 8'h31
`define KEY_5 8'h32
`define KEY_6 8'h33
`define KEY_7 8'h41
`define KEY_8 8'h42
`define KEY_9 8'h43
`define KEY_MHZ 8'h44
`define KEY_GHZ 8'h34
`define KEY_CLEAR_ENTRY 8'h24
`define KEY_POINT 8'h13
`define KEY_SIGN 8'h11
`define KEY_RESET 8'h47
`define KEY_TEST 8'h14
`define KEY_TEST_EXIT 8'h15
// --------
// tests and counts
// --------
`define TEST_SELF 4'h1
`define TEST_EIGHTS 4'h2
`define TEST_SEGMENT 4'h3
`define TEST_DIGIT 4'h4
`define TEST_KEYPAD 4'h5
`define TEST_BUS_ADDR 4'h7
`define TEST_OFFSET 4'h8
`define TEST_GAIN 4'h9
`define TEST_ALTER 4'hA
`define TEST_RAMP 4'h6
`define OFFSET_DIGITS 3'h4
`define GAIN_DIGITS 3'h5
`define ADDR_DIGITS 3'h4
`define DATA_DIGITS 3'h2
`define RAMP_TOP_MHZ 27000
`define DAC_LSB_MHZ 2
`define VCO_SELF_TEST_WORD 16'h2000
`define SEGMENTS 4'h8
`define DIGITS 4'hA
`define MAX_BUS_ADDR 5'h1E
`define INVALID_BUS_ADDR 8'h31
`endif

// ---- rtl/service_test_pkg.sv ----
// Purpose: types of the keypad service test sequencer
// Assumes: nothing
// Notes: constants live in the params header
package service_test_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'b0001, st_select = 4'b0010, st_number = 4'b0100, st_run = 4'b1000
  } seq_state_type;
  typedef enum logic [3:0] {
    alter_addr = 4'b0001, alter_read = 4'b0010, alter_data = 4'b0100, alter_write = 4'b1000
  } alter_state_type;
  typedef enum logic [2:0] {
    disp_normal = 3'h0, disp_all_on = 3'h1, disp_segment = 3'h2, disp_digit = 3'h3, disp_value = 3'h4
  } disp_mode_type;
  typedef struct packed {
    disp_mode_type mode;
    logic [3:0] index;
    logic [2:0] digits;
    logic [19:0] value;
  } display_type;
  typedef struct packed {
    logic strobe;
    logic [7:0] coord;
  } key_type;
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bus_req_type;
  typedef struct packed {
    logic [1:0] en;
    logic [2:0] pair;
    logic [7:0] a;
    logic [7:0] b;
  } port_write_type;
endpackage

// ---- rtl/keypad_service_test_sequencer.sv ----
// Purpose: keypad driven service test sequencer with port read/alter
// Assumes: key strobes come from a scanner on clk; port lines are pins
// Notes: port registers live here and drive port_out
//
// Behaviour
// RL1: ten tests, chosen by test key and two digits 01 to 10
// RL2: tests 01-07 except 05 end on any key, which then goes to normal use
// RL3: in tests 08-10 an unused key ends the test
// RL4: the exit key ends any test and returns to normal use
// RL5: digits map to 0-9; MHz GHz clear point sign reset map to A-F
// RL6: keypad test shows each pressed key's row/column code
// RL7: keypad test also entered by activity on a hardware entry line
// RL8: ramp test steps tuning DAC 0 to 27 GHz, 2 MHz per step
// RL9: self test sets VCO to 400 MHz and enables divide by two
// RL10: all-eights test lights every LED, annunciator and point
// RL11: segment test steps one segment at sample rate through all
// RL12: digit test steps one whole digit at sample rate through all
// RL13: test 07 shows switch bus address decimal, invalid if absent
// RL14: test 08 takes four digits; coarse then fine offset DAC
// RL15: test 09 takes five digits into two gain ports and amp bits
// RL16: fifth gain digit reduced to two bits
// RL17: test 10 reads address after fourth address digit
// RL18: then two digits write the location if RAM or port
// RL19: port read gives output bits programmed, input bits line level
// RL20: software tunes converter writing high then low tuning bytes; ramp test writes both tuning bytes in one cycle
// RL21: software sets VCO writing high then low program bytes; self test writes both program bytes in one cycle
// RL22: hex entry collects most significant digit first, shifting left
`timescale 1ns/1ps
`include "keypad_service_test_params.svh"
module keypad_service_test_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire service_test_pkg::key_type key_in,
  input wire logic keypad_entry_line,
  input wire logic sample_tick,
  input wire logic [7:0] bus_switch_line,
  input wire logic option_fitted_line,
  input wire logic [15:0][7:0] port_dir,
  input wire logic [15:0][7:0] port_line,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output service_test_pkg::bus_req_type mem_bus,
  output logic [15:0][7:0] port_out,
  output service_test_pkg::display_type display,
  output service_test_pkg::key_type fwd_key,
  output logic in_test,
  output logic divide_enable,
  output logic gain_high_15db,
  output logic gain_high_30db
);
  // ---------------------------------------------
  // constants
  // ---------------------------------------------
  localparam logic [15:0] PORT_ADDR [`NUM_PORTS] = '{
    `FRONT_PANEL_PORT_A, `FRONT_PANEL_PORT_B, `VCO_PROGRAM_LOW, `VCO_PROGRAM_HIGH,
    `TUNING_FREQ_LOW, `TUNING_FREQ_HIGH, `BAND2_CONVERTER_PORT_A, `BAND2_CONVERTER_PORT_B,
    `GATE_GENERATOR_PORT_A, `GATE_GENERATOR_PORT_B, `BCD_REMOTE_PORT_A, `BCD_REMOTE_PORT_B,
    `DAC_BOARD_PORT_A, `DAC_BOARD_PORT_B, `COUNT_CHAIN_PORT_A, `COUNT_CHAIN_PORT_B};
  localparam logic [13:0] RAMP_TOP = 14'(`RAMP_TOP_MHZ / `DAC_LSB_MHZ);

  // RL5 hex mapping
  function automatic logic [4:0] hex_of(input logic [7:0] c);
    case (c)
      `KEY_0: hex_of = 5'h10;
      `KEY_1: hex_of = 5'h11;
      `KEY_2: hex_of = 5'h12;
      `KEY_3: hex_of = 5'h13;
      `KEY_4: hex_of = 5'h14;
      `KEY_5: hex_of = 5'h15;
      `KEY_6: hex_of = 5'h16;
      `KEY_7: hex_of = 5'h17;
      `KEY_8: hex_of = 5'h18;
      `KEY_9: hex_of = 5'h19;
      `KEY_MHZ: hex_of = 5'h1A;
      `KEY_GHZ: hex_of = 5'h1B;
      `KEY_CLEAR_ENTRY: hex_of = 5'h1C;
      `KEY_POINT: hex_of = 5'h1D;
      `KEY_SIGN: hex_of = 5'h1E;
      `KEY_RESET: hex_of = 5'h1F;
      default: hex_of = 5'h00;
    endcase
  endfunction

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  service_test_pkg::seq_state_type state_reg;
  service_test_pkg::alter_state_type alter_reg;
  service_test_pkg::port_write_type pw_reg;
  service_test_pkg::bus_req_type mem_reg;
  service_test_pkg::key_type fwd_reg;
  service_test_pkg::display_type disp_reg;
  logic [3:0] test_reg;
  logic tens_reg;
  logic first_reg;
  logic [19:0] entry_reg;
  logic [2:0] count_reg;
  logic [15:0] addr_reg;
  logic [7:0] data_reg;
  logic [7:0] last_coord_reg;
  logic [13:0] ramp_reg;
  logic gain15_reg;
  logic gain30_reg;
  logic [15:0][7:0] port_out_reg;
  logic [15:0][7:0] line_s1_reg;
  logic [15:0][7:0] line_s2_reg;
  logic [7:0] sw_s1_reg;
  logic [7:0] sw_s2_reg;
  logic opt_s1_reg;
  logic opt_s2_reg;
  logic [2:0] strap_reg;

  // --------
  // pin synchronisers
  // --------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_s1_reg <= '0;
      line_s2_reg <= '0;
      sw_s1_reg <= 8'h00;
      sw_s2_reg <= 8'h00;
      opt_s1_reg <= 1'b0;
      opt_s2_reg <= 1'b0;
      strap_reg <= 3'h0;
    end else begin
      line_s1_reg <= port_line;
      line_s2_reg <= line_s1_reg;
      sw_s1_reg <= bus_switch_line;
      sw_s2_reg <= sw_s1_reg;
      opt_s1_reg <= option_fitted_line;
      opt_s2_reg <= opt_s1_reg;
      strap_reg <= {strap_reg[1:0], keypad_entry_line};
    end
  end

  // --------
  // decode
  // --------
  logic [4:0] hex_dec;
  logic key_hit;
  logic key_exit;
  logic key_test;
  logic hex_ok;
  logic [3:0] hex_nib;
  logic [19:0] new_entry;
  logic [4:0] sel_num;
  logic num_ok;
  logic running;
  logic uses_hex;
  logic hex_take;
  logic strap_edge;
  logic [`NUM_PORTS-1:0] port_hit;
  logic [15:0][7:0] port_rd;
  logic [3:0] hit_idx;
  logic any_port;
  logic sw_hit;
  logic ram_hit;

  assign hex_dec = hex_of(key_in.coord);
  assign key_hit = key_in.strobe;
  assign key_exit = key_in.coord == `KEY_TEST_EXIT;
  assign key_test = key_in.coord == `KEY_TEST;
  assign hex_ok = hex_dec[4];
  assign hex_nib = hex_dec[3:0];
  // RL22 shift left
  assign new_entry = {entry_reg[15:0], hex_nib};
  assign sel_num = tens_reg ? 5'hA + {1'b0, hex_nib} : {1'b0, hex_nib};
  assign num_ok = hex_ok && hex_nib <= 4'h9 && sel_num >= 5'h1 && sel_num <= 5'hA;
  assign running = state_reg == service_test_pkg::st_run;
  assign uses_hex = running && test_reg >= `TEST_OFFSET;
  assign hex_take = key_hit && hex_ok && uses_hex && !key_exit &&
                    (test_reg != `TEST_ALTER || alter_reg == service_test_pkg::alter_addr ||
                     alter_reg == service_test_pkg::alter_data);
  // RL7 line activity; only the second and third stages are compared
  assign strap_edge = strap_reg[1] ^ strap_reg[2];
  assign sw_hit = addr_reg == `BUS_ADDRESS_SWITCH;
  assign ram_hit = addr_reg < `RAM_LIMIT;

  generate
    for (genvar g = 0; g < `NUM_PORTS; g++) begin : g_port
      assign port_hit[g] = addr_reg == PORT_ADDR[g];
      // RL19 direction mux
      assign port_rd[g] = (port_dir[g] & port_out_reg[g]) | (~port_dir[g] & line_s2_reg[g]);
    end
  endgenerate

  always_comb begin
    hit_idx = 4'h0;
    for (int i = 0; i < `NUM_PORTS; i++) begin
      if (port_hit[i]) begin
        hit_idx = 4'(i);
      end
    end
  end
  assign any_port = |port_hit;

  // ---------------------------------------------
  // test selection and exit
  // ---------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= service_test_pkg::st_idle;
      test_reg <= 4'h0;
      tens_reg <= 1'b0;
      first_reg <= 1'b0;
      fwd_reg <= '0;
    end else begin
      fwd_reg.strobe <= 1'b0;
      first_reg <= 1'b0;
      if (strap_edge && !(running && test_reg == `TEST_KEYPAD)) begin
        // RL7 forced entry
        state_reg <= service_test_pkg::st_run;
        test_reg <= `TEST_KEYPAD;
        first_reg <= 1'b1;
      end else if (key_hit) begin
        unique case (state_reg)
          service_test_pkg::st_idle: begin
            // RL1 test key
            if (key_test) begin
              state_reg <= service_test_pkg::st_select;
            end else begin
              fwd_reg <= {1'b1, key_in.coord};
            end
          end
          service_test_pkg::st_select: begin
            if (hex_ok && hex_nib <= 4'h1) begin
              tens_reg <= hex_nib[0];
              state_reg <= service_test_pkg::st_number;
            end else begin
              state_reg <= service_test_pkg::st_idle;
            end
          end
          service_test_pkg::st_number: begin
            // RL1 range check
            if (num_ok) begin
              state_reg <= service_test_pkg::st_run;
              test_reg <= sel_num[3:0];
              first_reg <= 1'b1;
            end else begin
              state_reg <= service_test_pkg::st_idle;
            end
          end
          service_test_pkg::st_run: begin
            if (key_exit) begin
              // RL4 exit key
              state_reg <= service_test_pkg::st_idle;
            end else if (test_reg <= `TEST_BUS_ADDR && test_reg != `TEST_KEYPAD) begin
              // RL2 any key
              state_reg <= service_test_pkg::st_idle;
              fwd_reg <= {1'b1, key_in.coord};
            end else if (test_reg >= `TEST_OFFSET && !hex_ok) begin
              // RL3 unused key
              state_reg <= service_test_pkg::st_idle;
              fwd_reg <= {1'b1, key_in.coord};
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------
  // entry, ramp and read/alter
  // ---------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alter_reg <= service_test_pkg::alter_addr;
      entry_reg <= 20'h00000;
      count_reg <= 3'h0;
      addr_reg <= 16'h0000;
      data_reg <= 8'h00;
      ramp_reg <= 14'h0000;
      pw_reg <= '0;
      mem_reg <= '0;
      gain15_reg <= 1'b0;
      gain30_reg <= 1'b0;
    end else begin
      pw_reg.en <= 2'b00;
      if (!running) begin
        // abandons a pending bus cycle when the test is left
        mem_reg.req <= 1'b0;
      end
      if (first_reg) begin
        entry_reg <= 20'h00000;
        count_reg <= 3'h0;
        ramp_reg <= 14'h0000;
        alter_reg <= service_test_pkg::alter_addr;
        if (test_reg == `TEST_SELF) begin
          // RL9 vco to 400 MHz
          pw_reg <= {2'b11, `PAIR_VCO, 8'(`VCO_SELF_TEST_WORD), 8'(`VCO_SELF_TEST_WORD >> 8)};
        end
      end else if (running && test_reg == `TEST_RAMP) begin
        // RL8 continuous ramp
        ramp_reg <= (ramp_reg == RAMP_TOP) ? 14'h0000 : ramp_reg + 14'h0001;
        pw_reg <= {2'b11, `PAIR_TUNE, ramp_reg[7:0], 2'b00, ramp_reg[13:8]};
      end else if (hex_take) begin
        entry_reg <= new_entry;
        count_reg <= count_reg + 3'h1;
        if (test_reg == `TEST_OFFSET && count_reg == `OFFSET_DIGITS - 3'h1) begin
          // RL14 coarse then fine
          count_reg <= 3'h0;
          pw_reg <= {2'b11, `PAIR_DAC, new_entry[15:8], new_entry[7:0]};
        end else if (test_reg == `TEST_GAIN && count_reg == `GAIN_DIGITS - 3'h1) begin
          // RL15 gain ports
          count_reg <= 3'h0;
          pw_reg <= {2'b11, `PAIR_GATE, new_entry[19:12], new_entry[11:4]};
          // RL16 two bits
          gain15_reg <= hex_nib[0];
          gain30_reg <= hex_nib[1];
        end else if (test_reg == `TEST_ALTER) begin
          if (alter_reg == service_test_pkg::alter_addr && count_reg == `ADDR_DIGITS - 3'h1) begin
            // RL17 read on fourth
            count_reg <= 3'h0;
            addr_reg <= new_entry[15:0];
            alter_reg <= service_test_pkg::alter_read;
          end else if (alter_reg == service_test_pkg::alter_data &&
                       count_reg == `DATA_DIGITS - 3'h1) begin
            count_reg <= 3'h0;
            data_reg <= new_entry[7:0];
            alter_reg <= service_test_pkg::alter_addr;
            // RL18 writable only
            if (any_port) begin
              pw_reg <= {hit_idx[0] ? 2'b10 : 2'b01, hit_idx[3:1], new_entry[7:0], new_entry[7:0]};
            end else if (ram_hit) begin
              mem_reg <= {1'b1, 1'b1, addr_reg, new_entry[7:0]};
              alter_reg <= service_test_pkg::alter_write;
            end
          end
        end
      end else if (running && test_reg == `TEST_ALTER) begin
        if (alter_reg == service_test_pkg::alter_read) begin
          if (any_port) begin
            data_reg <= port_rd[hit_idx];
            alter_reg <= service_test_pkg::alter_data;
          end else if (sw_hit) begin
            data_reg <= sw_s2_reg;
            alter_reg <= service_test_pkg::alter_data;
          end else if (!mem_reg.req) begin
            mem_reg <= {1'b1, 1'b0, addr_reg, 8'h00};
          end else if (mem_ack) begin
            mem_reg.req <= 1'b0;
            data_reg <= mem_rdata;
            alter_reg <= service_test_pkg::alter_data;
          end
        end else if (alter_reg == service_test_pkg::alter_write && mem_ack) begin
          mem_reg.req <= 1'b0;
          alter_reg <= service_test_pkg::alter_addr;
        end
      end
    end
  end

  // ---------------------------------------------
  // port registers
  // ---------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_out_reg <= '0;
    end else begin
      if (pw_reg.en[0]) begin
        port_out_reg[{pw_reg.pair, 1'b0}] <= pw_reg.a;
      end
      if (pw_reg.en[1]) begin
        port_out_reg[{pw_reg.pair, 1'b1}] <= pw_reg.b;
      end
    end
  end

  // ---------------------------------------------
  // display
  // ---------------------------------------------
  logic [7:0] bus_addr_bcd;
  logic [4:0] sw_addr;
  always_comb begin
    sw_addr = sw_s2_reg[4:0];
    // RL13 decimal or invalid
    if (!opt_s2_reg || sw_addr > `MAX_BUS_ADDR) begin
      bus_addr_bcd = `INVALID_BUS_ADDR;
    end else if (sw_addr >= 5'h1E) begin
      bus_addr_bcd = {4'h3, 4'(sw_addr - 5'h1E)};
    end else if (sw_addr >= 5'h14) begin
      bus_addr_bcd = {4'h2, 4'(sw_addr - 5'h14)};
    end else if (sw_addr >= 5'hA) begin
      bus_addr_bcd = {4'h1, 4'(sw_addr - 5'hA)};
    end else begin
      bus_addr_bcd = {4'h0, sw_addr[3:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_reg.mode <= service_test_pkg::disp_normal;
      disp_reg.index <= 4'h0;
      disp_reg.digits <= 3'h0;
      disp_reg.value <= 20'h00000;
      last_coord_reg <= 8'h00;
    end else begin
      if (running && test_reg == `TEST_KEYPAD && key_hit && !key_exit) begin
        // RL6 show coordinate
        last_coord_reg <= key_in.coord;
      end
      if (first_reg) begin
        disp_reg.index <= 4'h0;
      end else if (running && sample_tick && test_reg == `TEST_SEGMENT) begin
        // RL11 step segment
        disp_reg.index <= (disp_reg.index == `SEGMENTS - 4'h1) ? 4'h0 : disp_reg.index + 4'h1;
      end else if (running && sample_tick && test_reg == `TEST_DIGIT) begin
        // RL12 step digit
        disp_reg.index <= (disp_reg.index == `DIGITS - 4'h1) ? 4'h0 : disp_reg.index + 4'h1;
      end
      disp_reg.mode <= service_test_pkg::disp_value;
      disp_reg.digits <= 3'h2;
      disp_reg.value <= 20'h00000;
      if (!running) begin
        disp_reg.mode <= service_test_pkg::disp_normal;
        disp_reg.digits <= 3'h0;
      end else if (test_reg == `TEST_EIGHTS) begin
        // RL10 all on
        disp_reg.mode <= service_test_pkg::disp_all_on;
      end else if (test_reg == `TEST_SEGMENT) begin
        disp_reg.mode <= service_test_pkg::disp_segment;
      end else if (test_reg == `TEST_DIGIT) begin
        disp_reg.mode <= service_test_pkg::disp_digit;
      end else if (test_reg == `TEST_KEYPAD) begin
        disp_reg.value <= {12'h000, last_coord_reg};
      end else if (test_reg == `TEST_BUS_ADDR) begin
        disp_reg.value <= {12'h000, bus_addr_bcd};
      end else if (test_reg == `TEST_ALTER && alter_reg == service_test_pkg::alter_data && count_reg == 3'h0) begin
        disp_reg.value <= {12'h000, data_reg};
      end else if (test_reg >= `TEST_OFFSET) begin
        disp_reg.value <= entry_reg;
        disp_reg.digits <= count_reg;
      end else begin
        disp_reg.mode <= service_test_pkg::disp_normal;
        disp_reg.digits <= 3'h0;
      end
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign mem_bus = mem_reg;
  assign port_out = port_out_reg;
  assign display = disp_reg;
  assign fwd_key = fwd_reg;
  assign in_test = running;
  // RL9 divider enable
  assign divide_enable = running && test_reg == `TEST_SELF;
  assign gain_high_15db = gain15_reg;
  assign gain_high_30db = gain30_reg;
endmodule

// ---- test/ksts_props.sv ----
// Purpose: port checks of the sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to the sequencer after the module
`timescale 1ns/1ps
`include "keypad_service_test_params.svh"
module ksts_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire service_test_pkg::key_type key_in,
  input wire logic mem_ack,
  input wire service_test_pkg::bus_req_type mem_bus,
  input wire logic [15:0][7:0] port_out,
  input wire service_test_pkg::display_type display,
  input wire service_test_pkg::key_type fwd_key,
  input wire logic in_test,
  input wire logic divide_enable
);
  wire [15:0] ramp = {port_out[5], port_out[4]};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // --------
  // properties
  // --------
  property p_exit;
    in_test && key_in.strobe && key_in.coord == `KEY_TEST_EXIT |=> !in_test && !fwd_key.strobe;
  endproperty
  a_exit: assert property (p_exit) else $error("exit key ignored");
  property p_fwd;
    in_test && display.mode == service_test_pkg::disp_all_on && key_in.strobe && key_in.coord != `KEY_TEST_EXIT
      |=> !in_test && fwd_key == {1'b1, $past(key_in.coord)};
  endproperty
  a_fwd: assert property (p_fwd) else $error("key not forwarded");
  property p_div;
    divide_enable [*4] |-> in_test && {port_out[3], port_out[2]} == `VCO_SELF_TEST_WORD;
  endproperty
  a_div: assert property (p_div) else $error("self test word wrong");
  property p_seg;
    display.mode == service_test_pkg::disp_segment && $past(display.mode) == service_test_pkg::disp_segment
      && $changed(display.index) |-> display.index == (($past(display.index) + 4'h1) % `SEGMENTS);
  endproperty
  a_seg: assert property (p_seg) else $error("segment step wrong");
  property p_dig;
    display.mode == service_test_pkg::disp_digit |-> display.index < `DIGITS;
  endproperty
  a_dig: assert property (p_dig) else $error("digit index range");
  // one step up or wrap at the top
  property p_ramp;
    $changed(ramp) |-> ramp == $past(ramp) + 16'h1 || ramp == 16'h0 && $past(ramp) == 16'h34BC;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp step wrong");
  property p_hold;
    mem_bus.req && !mem_ack && in_test && !key_in.strobe |=> mem_bus.req && $stable(mem_bus);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped");
  property p_ram;
    mem_bus.req && mem_bus.we |-> mem_bus.addr < `RAM_LIMIT;
  endproperty
  a_ram: assert property (p_ram) else $error("write outside ram");
  c_write: cover property (mem_bus.req && mem_bus.we && mem_ack);
  c_fwd: cover property (fwd_key.strobe);
  c_seg: cover property (display.mode == service_test_pkg::disp_segment && $changed(display.index));
endmodule
bind keypad_service_test_sequencer ksts_props i_props (.clk, .rst_n, .key_in, .mem_ack, .mem_bus, .port_out,
  .display, .fwd_key, .in_test, .divide_enable);

// ---- test/front_panel_model.sv ----
// Purpose: operator pressing front panel keys
// Assumes: strobe is one cycle, changed after rising edges
// Notes: idle coordinate lines carry the inverse of the last code
`timescale 1ns/1ps
module front_panel_model (
  input wire logic clk,
  output service_test_pkg::key_type key_out,
  output logic entry_line
);
  initial begin
    key_out = '0;
    entry_line = 1'b0;
  end
  // gap sets how slowly the operator moves on
  task automatic press(input logic [7:0] code, input int gap);
    @(posedge clk);
    key_out <= {1'b1, code};
    @(posedge clk);
    // stale code would hide a missing strobe check
    key_out <= {1'b0, ~code};
    repeat (gap) @(posedge clk);
  endtask
  task automatic tie_entry();
    repeat (4) begin
      @(posedge clk);
      entry_line <= ~entry_line;
    end
  endtask
endmodule

// ---- test/keypad_service_test_sequencer_tb.sv ----
// Purpose: directed tests of the sequencer
// Assumes: 125 MHz clock, reset held six cycles
// Notes: memory answers one cycle after each request
`timescale 1ns/1ps
`include "keypad_service_test_params.svh"
module keypad_service_test_sequencer_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic entry;
  logic tick = 1'b0;
  logic fitted = 1'b1;
  logic mem_ack = 1'b0;
  logic [7:0] last_fwd = 8'h00;
  logic [23:0] wr_seen = 24'h000000;
  logic [15:0] r0;
  int failures = 0;
  int cmp_count = 0;
  service_test_pkg::key_type key_in;
  service_test_pkg::bus_req_type mem_bus;
  logic [15:0][7:0] port_out;
  service_test_pkg::display_type display;
  service_test_pkg::key_type fwd_key;
  logic in_test, divide_enable, gain_high_15db, gain_high_30db;
  logic [7:0] hk [16] = '{`KEY_0, `KEY_1, `KEY_2, `KEY_3, `KEY_4, `KEY_5, `KEY_6, `KEY_7, `KEY_8, `KEY_9,
    `KEY_MHZ, `KEY_GHZ, `KEY_CLEAR_ENTRY, `KEY_POINT, `KEY_SIGN, `KEY_RESET};
  always #4 clk = ~clk;
  front_panel_model i_panel (.clk(clk), .key_out(key_in), .entry_line(entry));
  keypad_service_test_sequencer i_dut (.clk, .rst_n, .key_in, .keypad_entry_line(entry), .sample_tick(tick),
    .bus_switch_line(8'h0D), .option_fitted_line(fitted), .port_dir({16{8'h0F}}), .port_line({16{8'hA5}}),
    .mem_rdata(8'h5C), .mem_ack, .mem_bus, .port_out, .display, .fwd_key, .in_test, .divide_enable,
    .gain_high_15db, .gain_high_30db);
  always @(posedge clk) begin
    mem_ack <= mem_bus.req && !mem_ack;
    if (mem_bus.req && mem_ack && mem_bus.we) wr_seen <= {mem_bus.addr, mem_bus.wdata};
    if (fwd_key.strobe) last_fwd <= fwd_key.coord;
  end
  // --------
  // tasks
  // --------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hex(input logic [3:0] d);
    i_panel.press(hk[d], 8);
  endtask
  task automatic keys(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) hex(v[i*4 +: 4]);
  endtask
  task automatic sel(input int n);
    i_panel.press(`KEY_TEST, 0);
    hex(4'(n / 10));
    hex(4'(n % 10));
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
  // --------
  // tests
  // --------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    sel(2);
    chk(display.mode, service_test_pkg::disp_all_on);
    i_panel.press(`KEY_7, 3);
    chk({in_test, last_fwd}, {1'b0, `KEY_7});
    sel(1);
    chk({divide_enable, port_out[3], port_out[2]}, {1'b1, `VCO_SELF_TEST_WORD});
    i_panel.press(`KEY_TEST_EXIT, 3);
    chk({in_test, divide_enable, last_fwd}, {2'b00, `KEY_7});
    for (int n = 0; n < 12; n += 11) begin
      sel(n);
      chk(in_test, 1'b0);
    end
    $display("select done");
    for (int t = 3; t < 5; t++) begin
      sel(t);
      repeat (9) begin
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (2) @(posedge clk);
      end
      chk({display.mode, display.index}, t == 3 ? {service_test_pkg::disp_segment, 4'h1}
        : {service_test_pkg::disp_digit, 4'h9});
      i_panel.press(`KEY_TEST_EXIT, 3);
    end
    for (int f = 1; f >= 0; f--) begin
      fitted <= f[0];
      sel(7);
      chk(display.value[7:0], f ? 8'h13 : `INVALID_BUS_ADDR);
      i_panel.press(`KEY_1, 3);
    end
    $display("display done");
    sel(8);
    keys(16'hCDEF, 4);
    chk({port_out[12], port_out[13]}, 16'hCDEF);
    i_panel.press(8'h46, 3);
    chk({in_test, last_fwd}, 9'h046);
    sel(9);
    keys(16'h98BA, 4);
    hex(4'h6);
    chk({port_out[8], port_out[9], gain_high_30db, gain_high_15db}, {16'h98BA, 2'b10});
    i_panel.press(`KEY_TEST_EXIT, 3);
    sel(10);
    keys(16'h0100, 4);
    chk(display.value[7:0], 8'h5C);
    keys(16'h0024, 2);
    chk(wr_seen, 24'h010024);
    keys(16'hF000, 4);
    keys(16'h0057, 2);
    chk(wr_seen, 24'h010024);
    keys(16'h9902, 4);
    keys(16'h0036, 2);
    chk(port_out[9], 8'h36);
    keys(16'h9902, 4);
    chk(display.value[7:0], 8'hA6);
    i_panel.press(`KEY_TEST_EXIT, 3);
    $display("entry done");
    i_panel.tie_entry();
    repeat (6) @(posedge clk);
    chk(in_test, 1'b1);
    i_panel.press(`KEY_SIGN, 8);
    chk(display.value[7:0], `KEY_SIGN);
    i_panel.press(`KEY_TEST_EXIT, 8);
    sel(6);
    r0 = {port_out[5], port_out[4]};
    repeat (10) @(posedge clk);
    chk({port_out[5], port_out[4]}, r0 + 16'hA);
    i_panel.press(`KEY_1, 3);
    chk({in_test, last_fwd}, {1'b0, `KEY_1});
    $display("keypad and ramp done");
    results();
  end
endmodule
